// [src/ffosl_pkg.sv]
package ffosl_pkg;

	// offset word width, data port width
	localparam int OFFSET_BITS = 17;
	localparam int DATA_W = 36;

	// offset value loaded at master reset
	localparam logic [OFFSET_BITS-1:0] OFFSET_RST = 17'h0007F;

	// flag settle edges after the last offset bit
	localparam logic [1:0] FLAG_WAIT = 2'h2;

	// master reset pulse length in cycles
	localparam logic [1:0] MRS_CYCLES = 2'h2;

	// controller register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_EMPTY = 8'h04;
	localparam logic [7:0] ADDR_FULL = 8'h08;
	localparam logic [7:0] ADDR_MEMDATA = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADDR_READBACK = 8'h1C;

	// control register bits
	localparam int CTRL_START = 0;
	localparam int CTRL_MRS = 1;
	localparam int CTRL_PAUSE = 2;
	localparam int CTRL_READ = 3;

	// interrupt bits
	localparam int IRQ_LOAD_DONE = 0;
	localparam int IRQ_READ_DONE = 1;
	localparam int IRQ_MRS_DONE = 2;
	localparam int IRQ_W = 3;

endpackage : ffosl_pkg

// [src/ffosl_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ffosl_link_if #(
	parameter int DW = ffosl_pkg::DATA_W
);
	logic          masterResetN;
	logic          offsetLoadSelectN;
	logic          serialShiftEnableN;
	logic          writeEnableN;
	logic          readEnableN;
	logic          serialIn;
	logic [DW-1:0] inputDataPort;
	logic [DW-1:0] outputDataPort;
	logic          progAlmostEmptyN;
	logic          progAlmostFullN;

	// documented fifo end
	modport device (
		input  masterResetN,
		input  offsetLoadSelectN,
		input  serialShiftEnableN,
		input  writeEnableN,
		input  readEnableN,
		input  serialIn,
		input  inputDataPort,
		output outputDataPort,
		output progAlmostEmptyN,
		output progAlmostFullN
	);

	// controlling logic end
	modport ctrl (
		output masterResetN,
		output offsetLoadSelectN,
		output serialShiftEnableN,
		output writeEnableN,
		output readEnableN,
		output serialIn,
		output inputDataPort,
		input  outputDataPort,
		input  progAlmostEmptyN,
		input  progAlmostFullN
	);
endinterface : ffosl_link_if
`default_nettype wire

// [src/ffosl_fifo_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module ffosl_fifo_dev #(
	parameter int OB = ffosl_pkg::OFFSET_BITS,
	parameter int DW = ffosl_pkg::DATA_W
) (
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst,
	// link to the controller
	ffosl_link_if.device       link,
	// user side
	input  wire logic          wordRead,
	output logic               memWrite,
	output logic [DW-1:0]      memData,
	output logic [OB:0]        wordCount,
	output logic               serialMode,
	output logic [OB-1:0]      emptyOffset,
	output logic [OB-1:0]      fullOffset,
	output logic               loadActive
);
	localparam int LW = 2 * OB;
	localparam int PW = $clog2(LW);
	localparam logic [PW-1:0] LAST_BIT = PW'(LW - 1);
	localparam logic [OB:0] DEPTH = {1'b1, {OB{1'b0}}};

	typedef struct packed {
		logic          serialMode;
		logic [LW-1:0] offsets;
		logic [PW-1:0] bitPtr;
		logic          loading;
		logic [1:0]    paeWait;
		logic [1:0]    pafWait;
		logic          wrPtr;
		logic          rdPtr;
		logic [OB:0]   count;
		logic [DW-1:0] outData;
		logic          memWr;
		logic [DW-1:0] memData;
	} ffosl_dev_state_t;

	ffosl_dev_state_t state_r;
	ffosl_dev_state_t state_nxt;

	logic serialShift;
	logic parWrite;
	logic parRead;
	logic fifoWrite;
	logic fifoRead;
	logic paeValid;
	logic pafValid;
	logic [OB:0] fullLevel;

	// decode of the control pins
	always_comb begin
		serialShift = state_r.serialMode && !link.offsetLoadSelectN
			&& !link.serialShiftEnableN;
		parWrite = !state_r.serialMode && !link.offsetLoadSelectN
			&& !link.writeEnableN && link.readEnableN
			&& link.serialShiftEnableN;
		parRead = !link.offsetLoadSelectN && link.writeEnableN
			&& !link.readEnableN && link.serialShiftEnableN;
		fifoWrite = link.offsetLoadSelectN && !link.writeEnableN
			&& (state_r.count != DEPTH);
		fifoRead = wordRead && (state_r.count != '0);
	end

	// next state
	always_comb begin
		state_nxt = state_r;
		state_nxt.memWr = 1'b0;
		if (!link.masterResetN) begin
			state_nxt.serialMode = link.offsetLoadSelectN;
			state_nxt.offsets = {ffosl_pkg::OFFSET_RST,
				ffosl_pkg::OFFSET_RST};
			state_nxt.bitPtr = '0;
			state_nxt.loading = 1'b0;
			state_nxt.paeWait = '0;
			state_nxt.pafWait = '0;
			state_nxt.wrPtr = 1'b0;
			state_nxt.rdPtr = 1'b0;
			state_nxt.count = '0;
		end else begin
			// settle countdown of both flags
			if (state_r.paeWait != '0) begin
				state_nxt.paeWait = state_r.paeWait - 2'h1;
			end
			if (state_r.pafWait != '0) begin
				state_nxt.pafWait = state_r.pafWait - 2'h1;
			end
			// serial shift, pointer kept across pauses
			if (serialShift) begin
				state_nxt.offsets[state_r.bitPtr] = link.serialIn;
				if (state_r.bitPtr == LAST_BIT) begin
					state_nxt.bitPtr = '0;
					state_nxt.loading = 1'b0;
					state_nxt.pafWait = ffosl_pkg::FLAG_WAIT;
					state_nxt.paeWait = ffosl_pkg::FLAG_WAIT;
				end else begin
					state_nxt.bitPtr = state_r.bitPtr + PW'(1);
					state_nxt.loading = 1'b1;
				end
			end
			// parallel word write, high bits dropped
			if (parWrite) begin
				if (state_r.wrPtr) begin
					state_nxt.offsets[LW-1:OB] =
						link.inputDataPort[OB-1:0];
					state_nxt.pafWait = ffosl_pkg::FLAG_WAIT;
				end else begin
					state_nxt.offsets[OB-1:0] =
						link.inputDataPort[OB-1:0];
					state_nxt.paeWait = ffosl_pkg::FLAG_WAIT;
				end
				state_nxt.wrPtr = !state_r.wrPtr;
			end
			// parallel readback of one offset
			if (parRead) begin
				state_nxt.outData = '0;
				if (state_r.rdPtr) begin
					state_nxt.outData[OB-1:0] =
						state_r.offsets[LW-1:OB];
				end else begin
					state_nxt.outData[OB-1:0] =
						state_r.offsets[OB-1:0];
				end
				state_nxt.rdPtr = !state_r.rdPtr;
			end
			// memory write and occupancy
			if (fifoWrite) begin
				state_nxt.memWr = 1'b1;
				state_nxt.memData = link.inputDataPort;
			end
			case ({fifoWrite, fifoRead})
				2'b10: state_nxt.count = state_r.count + (OB+1)'(1);
				2'b01: state_nxt.count = state_r.count - (OB+1)'(1);
				default: state_nxt.count = state_r.count;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= '0;
			state_r.offsets <= {ffosl_pkg::OFFSET_RST,
				ffosl_pkg::OFFSET_RST};
		end else begin
			state_r <= state_nxt;
		end
	end

	// flag validity and thresholds, invalid shows deasserted
	always_comb begin
		pafValid = !state_r.loading && (state_r.pafWait == '0);
		paeValid = !state_r.loading && (state_r.paeWait == '0);
		fullLevel = DEPTH - {1'b0, state_r.offsets[LW-1:OB]};
		link.progAlmostFullN = !(pafValid
			&& (state_r.count >= fullLevel));
		link.progAlmostEmptyN = !(paeValid
			&& (state_r.count <= {1'b0, state_r.offsets[OB-1:0]}));
	end

	// outputs
	assign link.outputDataPort = state_r.outData;
	assign memWrite = state_r.memWr;
	assign memData = state_r.memData;
	assign wordCount = state_r.count;
	assign serialMode = state_r.serialMode;
	assign emptyOffset = state_r.offsets[OB-1:0];
	assign fullOffset = state_r.offsets[LW-1:OB];
	assign loadActive = state_r.loading;

endmodule : ffosl_fifo_dev
`default_nettype wire

// [src/ffosl_ctrl_host.sv]
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ffosl_ctrl_host #(
	parameter int OB = ffosl_pkg::OFFSET_BITS,
	parameter int DW = ffosl_pkg::DATA_W
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// software register port
	input  wire logic [7:0]   addr,
	input  wire logic [31:0]  wrData,
	input  wire logic         wrStrobe,
	input  wire logic         rdStrobe,
	output logic [31:0]       rdData,
	output logic              irq,
	// link to the fifo
	ffosl_link_if.ctrl        link
);
	localparam int LW = 2 * OB;
	localparam int PW = $clog2(LW);
	localparam logic [PW-1:0] LAST_BIT = PW'(LW - 1);
	localparam int IW = ffosl_pkg::IRQ_W;

	typedef enum logic [2:0] {
		ST_MRS, ST_IDLE, ST_SHIFT, ST_RDWAIT, ST_RDCAP
	} ffosl_st_t;

	typedef struct packed {
		ffosl_st_t     st;
		logic [1:0]    mrsCnt;
		logic [PW-1:0] bitPtr;
		logic [LW-1:0] offsets;
		logic [DW-1:0] memData;
		logic          memPend;
		logic          readPend;
		logic          paused;
		logic [IW-1:0] irqStat;
		logic [IW-1:0] irqMask;
		logic [DW-1:0] rdBack;
		logic [31:0]   rdData;
		logic          mrsN;
		logic          ld;
		logic          serial_shift_enable_n;
		logic          wen;
		logic          ren;
		logic          si;
		logic [DW-1:0] din;
	} ffosl_host_state_t;

	ffosl_host_state_t state_r;
	ffosl_host_state_t state_nxt;

	logic          wrCtrl;
	logic [IW-1:0] irqSet;
	logic          shiftOn;

	always_comb begin
		state_nxt = state_r;
		irqSet = '0;
		wrCtrl = wrStrobe && (addr == ffosl_pkg::ADDR_CTRL);
		shiftOn = !state_r.ld && !state_r.serial_shift_enable_n;
		// pins idle by default, data pins keep level
		state_nxt.ld = 1'b1;
		state_nxt.serial_shift_enable_n = 1'b1;
		state_nxt.wen = 1'b1;
		state_nxt.ren = 1'b1;
		state_nxt.mrsN = 1'b1;
		// software writes
		if (wrStrobe) begin
			unique case (addr)
				ffosl_pkg::ADDR_EMPTY:
					state_nxt.offsets[OB-1:0] = wrData[OB-1:0];
				ffosl_pkg::ADDR_FULL:
					state_nxt.offsets[LW-1:OB] = wrData[OB-1:0];
				ffosl_pkg::ADDR_MEMDATA: begin
					state_nxt.memData = wrData[DW-1:0];
					state_nxt.memPend = 1'b1;
				end
				ffosl_pkg::ADDR_IRQ_MASK:
					state_nxt.irqMask = wrData[IW-1:0];
				default: begin
				end
			endcase
		end
		if (wrCtrl) begin
			state_nxt.paused = wrData[ffosl_pkg::CTRL_PAUSE];
			if (wrData[ffosl_pkg::CTRL_READ]) begin
				state_nxt.readPend = 1'b1;
			end
		end
		unique case (state_r.st)
			ST_MRS: begin
				// select serial loading while reset is low
				state_nxt.mrsN = 1'b0;
				state_nxt.ld = 1'b1;
				state_nxt.bitPtr = '0;
				if (state_r.mrsCnt == ffosl_pkg::MRS_CYCLES) begin
					state_nxt.mrsN = 1'b1;
					state_nxt.st = ST_IDLE;
					irqSet[ffosl_pkg::IRQ_MRS_DONE] = 1'b1;
				end else begin
					state_nxt.mrsCnt = state_r.mrsCnt + 2'h1;
				end
			end
			ST_IDLE: begin
				if (wrCtrl && wrData[ffosl_pkg::CTRL_MRS]) begin
					state_nxt.st = ST_MRS;
					state_nxt.mrsCnt = '0;
				end else if (state_r.memPend) begin
					state_nxt.wen = 1'b0;
					state_nxt.din = state_r.memData;
					state_nxt.memPend = 1'b0;
				end else if (state_r.readPend) begin
					state_nxt.ld = 1'b0;
					state_nxt.ren = 1'b0;
					state_nxt.readPend = 1'b0;
					state_nxt.st = ST_RDWAIT;
				end else if (wrCtrl && wrData[ffosl_pkg::CTRL_START]) begin
					// always the whole set of both offsets
					state_nxt.bitPtr = '0;
					state_nxt.st = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				// a bit shown this cycle is taken at the edge
				if (shiftOn) begin
					state_nxt.bitPtr = state_r.bitPtr + PW'(1);
				end
				if (shiftOn && state_r.bitPtr == LAST_BIT) begin
					state_nxt.bitPtr = '0;
					state_nxt.st = ST_IDLE;
					irqSet[ffosl_pkg::IRQ_LOAD_DONE] = 1'b1;
				end else if (state_r.memPend) begin
					// interleaved memory write, ld and sen high
					state_nxt.wen = 1'b0;
					state_nxt.din = state_r.memData;
					state_nxt.memPend = 1'b0;
				end else if (state_nxt.paused) begin
					// pause by raising only the shift enable
					state_nxt.ld = 1'b0;
				end else begin
					state_nxt.ld = 1'b0;
					state_nxt.serial_shift_enable_n = 1'b0;
					state_nxt.si = state_r.offsets[state_nxt.bitPtr];
				end
			end
			ST_RDWAIT: begin
				state_nxt.st = ST_RDCAP;
			end
			ST_RDCAP: begin
				state_nxt.rdBack = link.outputDataPort;
				irqSet[ffosl_pkg::IRQ_READ_DONE] = 1'b1;
				state_nxt.st = ST_IDLE;
			end
		endcase
		// sticky status, set wins over clear
		state_nxt.irqStat = state_r.irqStat | irqSet;
		if (wrStrobe && addr == ffosl_pkg::ADDR_IRQ_STAT) begin
			state_nxt.irqStat = (state_r.irqStat & ~wrData[IW-1:0])
				| irqSet;
		end
		// read data for one cycle only
		state_nxt.rdData = '0;
		if (rdStrobe) begin
			unique case (addr)
				ffosl_pkg::ADDR_CTRL:
					state_nxt.rdData[ffosl_pkg::CTRL_PAUSE] = state_r.paused;
				ffosl_pkg::ADDR_EMPTY:
					state_nxt.rdData[OB-1:0] = state_r.offsets[OB-1:0];
				ffosl_pkg::ADDR_FULL:
					state_nxt.rdData[OB-1:0] = state_r.offsets[LW-1:OB];
				ffosl_pkg::ADDR_STATUS: begin
					state_nxt.rdData[PW-1:0] = state_r.bitPtr;
					state_nxt.rdData[8] = (state_r.st != ST_IDLE);
					state_nxt.rdData[9] = state_r.memPend;
					state_nxt.rdData[10] = link.progAlmostEmptyN;
					state_nxt.rdData[11] = link.progAlmostFullN;
				end
				ffosl_pkg::ADDR_IRQ_STAT:
					state_nxt.rdData[IW-1:0] = state_r.irqStat;
				ffosl_pkg::ADDR_IRQ_MASK:
					state_nxt.rdData[IW-1:0] = state_r.irqMask;
				ffosl_pkg::ADDR_READBACK:
					state_nxt.rdData[31:0] = state_r.rdBack[31:0];
				default: state_nxt.rdData = '0;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= '0;
			state_r.st <= ST_MRS;
			state_r.ld <= 1'b1;
			state_r.serial_shift_enable_n <= 1'b1;
			state_r.wen <= 1'b1;
			state_r.ren <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs from flops
	assign link.masterResetN = state_r.mrsN;
	assign link.offsetLoadSelectN = state_r.ld;
	assign link.serialShiftEnableN = state_r.serial_shift_enable_n;
	assign link.writeEnableN = state_r.wen;
	assign link.readEnableN = state_r.ren;
	assign link.serialIn = state_r.si;
	assign link.inputDataPort = state_r.din;
	assign rdData = state_r.rdData;
	assign irq = |(state_r.irqStat & state_r.irqMask);

endmodule : ffosl_ctrl_host
`default_nettype wire

// [tb/ffosl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ffosl_chk #(
	parameter int OB = 17
) (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// link controls
	input wire logic        masterResetN,
	input wire logic        offsetLoadSelectN,
	input wire logic        serialShiftEnableN,
	input wire logic        writeEnableN,
	input wire logic        readEnableN,
	input wire logic        serialIn,
	input wire logic [35:0] inputDataPort,
	// link returns
	input wire logic [35:0] outputDataPort,
	input wire logic        progAlmostEmptyN,
	input wire logic        progAlmostFullN
);
	logic            shift;
	logic            rdEdge;
	logic [5:0]      bitCnt_r;
	logic            rdSel_r;
	logic [2*OB-1:0] shadow_r;
	// shift and readback strobes seen on the wires
	assign shift = !offsetLoadSelectN && !serialShiftEnableN;
	assign rdEdge = !offsetLoadSelectN && writeEnableN && !readEnableN
		&& serialShiftEnableN;
	// shadow copy of the offsets and both pointers
	always_ff @(posedge sys_clk) begin
		if (rst || !masterResetN) begin
			bitCnt_r <= 6'h00;
			rdSel_r <= 1'b0;
			shadow_r <= {2{ffosl_pkg::OFFSET_RST[OB-1:0]}};
		end else begin
			if (shift) begin
				shadow_r[bitCnt_r] <= serialIn;
				bitCnt_r <= (bitCnt_r == 6'(2*OB-1)) ? 6'h00 : bitCnt_r + 6'h01;
			end
			if (rdEdge)
				rdSel_r <= !rdSel_r;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// edge that takes the final offset bit
	sequence lastBit;
		shift && bitCnt_r == 6'(2*OB-1);
	endsequence
	sequence bothHigh;
		progAlmostFullN && progAlmostEmptyN;
	endsequence
	mrs_select_a: assert property (
		!masterResetN |-> offsetLoadSelectN) else $error("select low in reset");
	no_parallel_a: assert property (
		!offsetLoadSelectN && serialShiftEnableN |-> writeEnableN)
		else $error("parallel write in serial mode");
	flags_invalid_a: assert property (
		bitCnt_r != 6'h00 |-> bothHigh) else $error("flag valid mid load");
	paf_settle_a: assert property (
		lastBit |=> progAlmostFullN[*2]) else $error("full flag too early");
	pae_settle_a: assert property (
		lastBit |=> progAlmostEmptyN[*2]) else $error("empty flag too early");
	readback_val_a: assert property (
		rdEdge && bitCnt_r == 6'h00 |=> outputDataPort == {{(36-OB){1'b0}},
		$past(rdSel_r) ? shadow_r[2*OB-1:OB] : shadow_r[OB-1:0]})
		else $error("readback value wrong");
	memwr_hold_a: assert property (
		!writeEnableN && bitCnt_r != 6'h00 |-> offsetLoadSelectN
		&& serialShiftEnableN) else $error("memory write disturbs shift");
	whole_load_a: assert property (
		bitCnt_r != 6'h00 |-> masterResetN) else $error("load cut by reset");
endmodule : ffosl_chk
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        sys_clk, rst, wrStrobe, rdStrobe, irq, wordRead;
	logic        memWrite, serialMode, loadActive;
	logic [7:0]  addr;
	logic [31:0] wrData, rdData;
	logic [35:0] memData, lastMem, rv, pv;
	logic [17:0] wordCount;
	logic [16:0] emptyOffset, fullOffset;
	int          errCount, checked, i;
	ffosl_link_if lnk ();
	ffosl_fifo_dev ffosl_fifo_dev_i (.sys_clk(sys_clk),
		.rst(rst), .link(lnk.device), .wordRead(wordRead), .memWrite(memWrite),
		.memData(memData), .wordCount(wordCount), .serialMode(serialMode),
		.emptyOffset(emptyOffset), .fullOffset(fullOffset),
		.loadActive(loadActive));
	ffosl_ctrl_host ffosl_ctrl_host_i (.sys_clk(sys_clk),
		.rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .irq(irq), .link(lnk.ctrl));
	ffosl_chk #(.OB(17)) ffosl_chk_i (.sys_clk(sys_clk), .rst(rst),
		.masterResetN(lnk.masterResetN), .offsetLoadSelectN(lnk.offsetLoadSelectN),
		.serialShiftEnableN(lnk.serialShiftEnableN),
		.writeEnableN(lnk.writeEnableN), .readEnableN(lnk.readEnableN),
		.serialIn(lnk.serialIn), .inputDataPort(lnk.inputDataPort),
		.outputDataPort(lnk.outputDataPort),
		.progAlmostEmptyN(lnk.progAlmostEmptyN),
		.progAlmostFullN(lnk.progAlmostFullN));
	// clock
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	// last word written into fifo memory
	always @(posedge sys_clk) if (memWrite) lastMem <= memData;
	task complete_run;
		if (errCount == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task cmp(input logic [35:0] g, input logic [35:0] e);
		checked++;
		if (g !== e) begin
			errCount++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge sys_clk);
		wrStrobe <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge sys_clk);
		rdStrobe <= 1'b0;
		#1;
		rv = 36'(rdData);
	endtask : rd
	task settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle
	// poll busy until the controller is idle
	task wait_idle;
		rd(ffosl_pkg::ADDR_STATUS);
		for (i = 0; i < 80 && rv[8] !== 1'b0; i++)
			rd(ffosl_pkg::ADDR_STATUS);
		cmp(36'(rv[8]), 36'h0);
	endtask : wait_idle
	// main sequence
	initial begin
		rst = 1'b1;
		{wrStrobe, rdStrobe, wordRead} = 3'h0;
		addr = 8'h00;
		wrData = 32'h0;
		{errCount, checked} = 0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		settle(8);
		wait_idle;
		cmp(36'(serialMode), 36'h1);
		cmp(36'(emptyOffset), 36'(ffosl_pkg::OFFSET_RST));
		rd(ffosl_pkg::ADDR_IRQ_STAT);
		cmp(rv, 36'h4);
		cmp(36'(irq), 36'h0);
		wr(ffosl_pkg::ADDR_IRQ_MASK, 32'h7);
		settle(1);
		cmp(36'(irq), 36'h1);
		wr(ffosl_pkg::ADDR_IRQ_STAT, 32'h4);
		settle(1);
		cmp(36'(irq), 36'h0);
		wr(ffosl_pkg::ADDR_EMPTY, 32'hFFFE0005);
		wr(ffosl_pkg::ADDR_FULL, 32'h0001FFFF);
		wr(ffosl_pkg::ADDR_CTRL, 32'h1);
		settle(10);
		wr(ffosl_pkg::ADDR_CTRL, 32'h4);
		wr(ffosl_pkg::ADDR_MEMDATA, 32'h0000ABCD);
		rd(ffosl_pkg::ADDR_STATUS);
		pv = rv;
		cmp(36'(loadActive), 36'h1);
		cmp(36'(pv[11:10]), 36'h3);
		settle(8);
		rd(ffosl_pkg::ADDR_STATUS);
		cmp(36'(rv[5:0]), 36'(pv[5:0]));
		wr(ffosl_pkg::ADDR_CTRL, 32'h0);
		wait_idle;
		cmp(36'(emptyOffset), 36'h5);
		cmp(36'(fullOffset), 36'h1FFFF);
		cmp(lastMem, 36'hABCD);
		cmp(36'(wordCount), 36'h1);
		cmp(36'(loadActive), 36'h0);
		settle(3);
		rd(ffosl_pkg::ADDR_STATUS);
		cmp(36'(rv[11:10]), 36'h0);
		rd(ffosl_pkg::ADDR_IRQ_STAT);
		cmp(rv, 36'h1);
		for (i = 0; i < 2; i++) begin
			wr(ffosl_pkg::ADDR_CTRL, 32'h8);
			settle(4);
			rd(ffosl_pkg::ADDR_READBACK);
			cmp(rv, i == 0 ? 36'h5 : 36'h1FFFF);
		end
		rd(ffosl_pkg::ADDR_IRQ_STAT);
		cmp(rv, 36'h3);
		wr(ffosl_pkg::ADDR_IRQ_STAT, 32'h7);
		settle(1);
		cmp(36'(irq), 36'h0);
		wr(ffosl_pkg::ADDR_EMPTY, 32'h3);
		wr(ffosl_pkg::ADDR_FULL, 32'h0);
		wr(ffosl_pkg::ADDR_CTRL, 32'h1);
		settle(3);
		wait_idle;
		cmp({fullOffset, 2'h0, emptyOffset}, 36'h3);
		settle(3);
		rd(ffosl_pkg::ADDR_STATUS);
		cmp(36'(rv[11:10]), 36'h2);
		@(posedge sys_clk) wordRead <= 1'b1;
		@(posedge sys_clk) wordRead <= 1'b0;
		settle(1);
		cmp(36'(wordCount), 36'h0);
		rd(8'h40);
		cmp(rv, 36'h0);
		complete_run;
	end
	// watchdog
	initial begin
		#200000;
		errCount++;
		complete_run;
	end
endmodule : tb
`default_nettype wire
